// >>> verilog/osm_consts.svh
// Constants of the oscillator select and fail-safe monitor block.
// Assumes a 40 MHz reference clock and a 32-bit AHB-Lite register port.
`ifndef OSM_CONSTS_SVH
`define OSM_CONSTS_SVH

// Register byte offsets; the decode looks at address bits 11:2 only.
`define OSM_ADDR_CTRL 12'h000
`define OSM_ADDR_TRIM 12'h004
`define OSM_ADDR_STAT 12'h008

// Control register field positions.
`define OSM_CUR_HI 14
`define OSM_CUR_LO 12
`define OSM_NEW_HI 10
`define OSM_NEW_LO 8
`define OSM_LOCK_BIT 5
`define OSM_FAIL_BIT 3
`define OSM_SEC_EN_BIT 1
`define OSM_SWREQ_BIT 0
`define OSM_TRIM_HI 3

// Group codes.
`define OSM_GRP_PLL 3'h7
`define OSM_GRP_EXT 3'h3
`define OSM_GRP_LOW_POWER_INTERNAL_RC 3'h2
`define OSM_GRP_FRC 3'h1
`define OSM_GRP_SEC 3'h0

// Primary selection codes that route the fast RC through the PLL.
`define OSM_FPR_FRC_X4 5'h05
`define OSM_FPR_FRC_X8 5'h06
`define OSM_FPR_FRC_X16 5'h07
// Primary selection codes of the plain crystal modes.
`define OSM_FPR_LOW_RANGE 5'h00
`define OSM_FPR_STANDARD 5'h04
`define OSM_FPR_HIGH_SPEED 5'h02

// Reset values.
`define OSM_TRIM_RST 4'h0
`define OSM_HRESP_OKAY 1'b0

// Timing: start-up length in oscillator periods, and the slowest healthy period.
`define OSM_STARTUP_PERIODS 1024
`define OSM_CLK_MHZ 40
`define OSM_FAIL_PERIOD_NS 10000
`define OSM_FAIL_CYCLES ((`OSM_FAIL_PERIOD_NS * `OSM_CLK_MHZ) / 1000)

`endif

// >>> verilog/osm_pkg.sv
// Types shared by the oscillator select and fail-safe monitor block.
// Assumes the constants header is compiled alongside.
package osm_pkg;
  typedef logic [2:0] osm_group_t;
  typedef logic [4:0] osm_fpr_t;
  typedef logic [1:0] osm_cfg_t;
  typedef logic [3:0] osm_trim_t;
  typedef logic [1:0] osm_gain_t;
  typedef enum logic [0:0] {OSM_SW_IDLE, OSM_SW_WAIT} osm_sw_state_t;
endpackage

// >>> verilog/osm_osc_watch.sv
// Samples one oscillator pin, reports its rising edges and a stall.
// Assumes the pin toggles no faster than half the reference clock.
`timescale 1ns/1ps
`include "osm_consts.svh"
module osm_osc_watch (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Oscillator pin.
  input wire logic osc_pin,
  // Findings.
  output logic osc_edge,
  output logic osc_stalled
);
  localparam int STALL_CYCLES = `OSM_FAIL_CYCLES;
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic [9:0] quiet_cnt;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= osc_pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign osc_edge = sync_b & ~sync_c;

  // A period longer than the slowest healthy one counts as a stall.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || osc_edge) begin
      quiet_cnt <= 10'h000;
      osc_stalled <= 1'b0;
    end else if (quiet_cnt >= 10'(STALL_CYCLES)) begin
      osc_stalled <= 1'b1;
    end else begin
      quiet_cnt <= quiet_cnt + 10'h001;
    end
  end
endmodule // osm_osc_watch

// >>> verilog/osm_startup_timer.sv
// Counts oscillator periods after a restart and flags when enough have passed.
// Assumes osc_edge is a one-cycle pulse on the reference clock.
`timescale 1ns/1ps
`include "osm_consts.svh"
module osm_startup_timer (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control.
  input wire logic restart,
  input wire logic osc_edge,
  // Status.
  output logic done
);
  logic [9:0] period_cnt;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || restart) begin
      period_cnt <= 10'h000;
      done <= 1'b0;
    end else if (osc_edge && !done) begin
      period_cnt <= period_cnt + 10'h001;
      if (period_cnt == 10'(`OSM_STARTUP_PERIODS - 1)) begin
        done <= 1'b1;
      end
    end
  end
endmodule // osm_startup_timer

// >>> verilog/osm_top.sv
// Oscillator group selection, start-up gating, clock switching and fail-safe monitor.
// Assumes configuration fuses are static and sleep and watchdog enable are on ref_clk.
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "osm_consts.svh"
module osm_top (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Configuration fuses.
  input wire osm_pkg::osm_group_t group_select_config,
  input wire osm_pkg::osm_fpr_t primary_select_config,
  input wire osm_pkg::osm_cfg_t switch_monitor_config,
  // Core and power state.
  input wire logic sleep,
  input wire logic watchdog_enable,
  input wire logic power_up_timer_done_pin,
  // Oscillator pins.
  input wire logic pri_osc_pin,
  input wire logic sec_osc_pin,
  input wire logic pll_lock_pin,
  // Clock tree control.
  output osm_pkg::osm_group_t sys_group,
  output logic sys_clk_release,
  output logic pll_enable,
  output logic pll_from_fast_rc,
  output osm_pkg::osm_gain_t pll_gain,
  output osm_pkg::osm_trim_t fast_rc_trim,
  output logic pri_osc_run,
  output logic sec_osc_run,
  output logic fast_rc_run,
  output logic low_power_internal_rc_run,
  output logic clock_fail_trap
);
  import osm_pkg::*;

  // True when the PLL group takes the fast RC instead of the primary pins.
  function automatic logic pll_uses_fast_rc(input osm_fpr_t fpr);
    return fpr == `OSM_FPR_FRC_X4 || fpr == `OSM_FPR_FRC_X8 || fpr == `OSM_FPR_FRC_X16;
  endfunction

  function automatic logic uses_primary(input osm_group_t grp, input osm_fpr_t fpr);
    return grp == `OSM_GRP_EXT || (grp == `OSM_GRP_PLL && !pll_uses_fast_rc(fpr));
  endfunction

  // Crystal modes of the primary pins; other modes need no start-up wait.
  function automatic logic is_crystal(input osm_group_t grp, input osm_fpr_t fpr);
    if (grp == `OSM_GRP_EXT) begin
      return fpr == `OSM_FPR_LOW_RANGE || fpr == `OSM_FPR_STANDARD ||
             fpr == `OSM_FPR_HIGH_SPEED;
    end
    return grp == `OSM_GRP_PLL && fpr[4];
  endfunction

  osm_group_t current_group_field;
  osm_group_t new_group_field;
  logic secondary_osc_enable;
  logic clock_fail_flag;
  logic switch_request_bit;
  osm_trim_t fast_rc_trim_field;
  osm_sw_state_t sw_state;

  logic switch_off;
  logic monitor_on;
  logic [1:0] lock_sync;
  logic [1:0] power_up_timer_sync;
  logic power_up_timer_seen;
  logic power_up_timer_rise;
  logic sleep_q;
  logic wake;
  logic pri_edge;
  logic sec_edge;
  logic pri_stalled;
  logic sec_stalled;
  logic main_done;
  logic tgt_done;
  logic tgt_restart;
  logic tgt_edge;
  logic tgt_ready;
  logic main_ready;
  logic fail_now;
  logic sw_start;
  logic sw_abort;

  // AHB-Lite bookkeeping.
  logic addr_take;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic wr_ctrl;
  logic wr_trim;

  assign switch_off = switch_monitor_config[1];
  assign monitor_on = switch_monitor_config == 2'h0;

  // Both oscillator pins get the same sampling and stall watch.
  logic [1:0] pin_vec;
  logic [1:0] edge_vec;
  logic [1:0] stall_vec;
  assign pin_vec = {sec_osc_pin, pri_osc_pin};
  for (genvar i = 0; i < 2; i++) begin : g_watch
    osm_osc_watch u_watch (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .osc_pin(pin_vec[i]),
      .osc_edge(edge_vec[i]),
      .osc_stalled(stall_vec[i])
    );
  end
  assign pri_edge = edge_vec[0];
  assign sec_edge = edge_vec[1];
  assign pri_stalled = stall_vec[0];
  assign sec_stalled = stall_vec[1];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_sync <= 2'h0;
      power_up_timer_sync <= 2'h0;
      power_up_timer_seen <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      lock_sync <= {lock_sync[0], pll_lock_pin};
      power_up_timer_sync <= {power_up_timer_sync[0], power_up_timer_done_pin};
      power_up_timer_seen <= power_up_timer_sync[1];
      sleep_q <= sleep;
    end
  end
  assign power_up_timer_rise = power_up_timer_sync[1] & ~power_up_timer_seen;
  assign wake = sleep_q & ~sleep;

  // Main start-up timer: restarted by reset and by each wake from sleep.
  osm_startup_timer u_main_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .restart(wake || sleep),
    .osc_edge(pri_edge),
    .done(main_done)
  );
  assign main_ready = !is_crystal(current_group_field, primary_select_config) || main_done;

  // Target timer counts the periods of the source being switched to.
  assign tgt_edge = uses_primary(new_group_field, primary_select_config) ? pri_edge : sec_edge;
  osm_startup_timer u_tgt_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .restart(tgt_restart),
    .osc_edge(tgt_edge),
    .done(tgt_done)
  );
  // A secondary that is already enabled is taken at once; a disabled one never completes.
  always_comb begin
    if (new_group_field == `OSM_GRP_SEC) begin
      tgt_ready = secondary_osc_enable;
    end else if (is_crystal(new_group_field, primary_select_config)) begin
      tgt_ready = tgt_done;
    end else begin
      tgt_ready = 1'b1;
    end
  end

  // Fail-safe detection: a stalled running source, or power-up expiry before start.
  always_comb begin
    fail_now = 1'b0;
    if (monitor_on && current_group_field != `OSM_GRP_FRC && !sleep) begin
      if (sys_clk_release && uses_primary(current_group_field, primary_select_config) &&
          pri_stalled) begin
        fail_now = 1'b1;
      end
      if (sys_clk_release && current_group_field == `OSM_GRP_SEC && sec_stalled) begin
        fail_now = 1'b1;
      end
      if (power_up_timer_rise && is_crystal(current_group_field, primary_select_config) && !main_done) begin
        fail_now = 1'b1;
      end
    end
  end

  // Bus: address phase captured when the bus is ready; every answer is zero-wait.
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_ctrl = wr_pend && wr_addr == `OSM_ADDR_CTRL;
  assign wr_trim = wr_pend && wr_addr == `OSM_ADDR_TRIM;
  assign sw_start = wr_ctrl && hwdata[`OSM_SWREQ_BIT] && !switch_request_bit && !switch_off;
  assign sw_abort = wr_ctrl && !hwdata[`OSM_SWREQ_BIT];
  assign tgt_restart = sw_start;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= addr_take && hwrite;
      wr_addr <= {haddr[11:2], 2'h0};
    end
  end

  // Read data is latched in the address phase, so it shows the state before
  // a write that sits in the same cycle's data phase.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      unique case ({haddr[11:2], 2'h0})
        `OSM_ADDR_CTRL: begin
          hrdata <= 32'h0000_0000;
          hrdata[`OSM_CUR_HI:`OSM_CUR_LO] <= current_group_field;
          hrdata[`OSM_NEW_HI:`OSM_NEW_LO] <= new_group_field;
          hrdata[`OSM_LOCK_BIT] <= lock_sync[1];
          hrdata[`OSM_FAIL_BIT] <= clock_fail_flag;
          hrdata[`OSM_SEC_EN_BIT] <= secondary_osc_enable;
          hrdata[`OSM_SWREQ_BIT] <= switch_request_bit;
        end
        `OSM_ADDR_TRIM: hrdata <= {28'h000_0000, fast_rc_trim_field};
        `OSM_ADDR_STAT: begin
          hrdata <= {14'h0000, switch_monitor_config, 1'b0, group_select_config,
                     3'h0, primary_select_config, 2'h0, power_up_timer_seen, main_done};
        end
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp <= `OSM_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `OSM_HRESP_OKAY;
    end
  end

  // Software-owned fields.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      new_group_field <= group_select_config;
      secondary_osc_enable <= 1'b0;
      fast_rc_trim_field <= `OSM_TRIM_RST;
    end else begin
      if (wr_ctrl) begin
        new_group_field <= hwdata[`OSM_NEW_HI:`OSM_NEW_LO];
        secondary_osc_enable <= hwdata[`OSM_SEC_EN_BIT];
      end
      if (wr_trim) begin
        fast_rc_trim_field <= hwdata[`OSM_TRIM_HI:0];
      end
    end
  end

  // Clock-fail flag: the hardware set wins over a software clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clock_fail_flag <= 1'b0;
    end else if (fail_now) begin
      clock_fail_flag <= 1'b1;
    end else if (wr_ctrl && !hwdata[`OSM_FAIL_BIT]) begin
      clock_fail_flag <= 1'b0;
    end
  end

  // Switch sequencer and current group.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      current_group_field <= group_select_config;
      switch_request_bit <= 1'b0;
      sw_state <= OSM_SW_IDLE;
    end else if (switch_off) begin
      current_group_field <= group_select_config;
      switch_request_bit <= 1'b0;
      sw_state <= OSM_SW_IDLE;
    end else if (fail_now) begin
      current_group_field <= `OSM_GRP_FRC;
      switch_request_bit <= 1'b0;
      sw_state <= OSM_SW_IDLE;
    end else begin
      unique case (sw_state)
        OSM_SW_IDLE: begin
          if (sw_start) begin
            switch_request_bit <= 1'b1;
            sw_state <= OSM_SW_WAIT;
          end
        end
        OSM_SW_WAIT: begin
          if (sw_abort) begin
            switch_request_bit <= 1'b0;
            sw_state <= OSM_SW_IDLE;
          end else if (tgt_ready) begin
            current_group_field <= new_group_field;
            switch_request_bit <= 1'b0;
            sw_state <= OSM_SW_IDLE;
          end
        end
      endcase
    end
  end

  // Clock tree outputs.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sys_group <= `OSM_GRP_FRC;
      sys_clk_release <= 1'b0;
      pll_enable <= 1'b0;
      pll_from_fast_rc <= 1'b0;
      pll_gain <= 2'h1;
      fast_rc_trim <= `OSM_TRIM_RST;
      clock_fail_trap <= 1'b0;
    end else begin
      sys_group <= current_group_field;
      if (current_group_field == `OSM_GRP_SEC) begin
        sys_clk_release <= secondary_osc_enable;
      end else begin
        sys_clk_release <= main_ready && !fail_now;
      end
      pll_enable <= current_group_field == `OSM_GRP_PLL && !sleep;
      pll_from_fast_rc <= pll_uses_fast_rc(primary_select_config);
      pll_gain <= primary_select_config[1:0];
      fast_rc_trim <= fast_rc_trim_field;
      clock_fail_trap <= fail_now;
    end
  end

  // Oscillator enables.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pri_osc_run <= 1'b0;
      sec_osc_run <= 1'b0;
      fast_rc_run <= 1'b0;
      low_power_internal_rc_run <= 1'b1;
    end else begin
      pri_osc_run <= !sleep && !fail_now &&
                     (uses_primary(current_group_field, primary_select_config) ||
                      (sw_state == OSM_SW_WAIT &&
                       uses_primary(new_group_field, primary_select_config)));
      sec_osc_run <= secondary_osc_enable;
      fast_rc_run <= current_group_field == `OSM_GRP_FRC || fail_now ||
                     (current_group_field == `OSM_GRP_PLL &&
                      pll_uses_fast_rc(primary_select_config));
      if (!power_up_timer_seen) begin
        low_power_internal_rc_run <= 1'b1;
      end else if (monitor_on) begin
        low_power_internal_rc_run <= !sleep;
      end else begin
        low_power_internal_rc_run <= watchdog_enable || current_group_field == `OSM_GRP_LOW_POWER_INTERNAL_RC;
      end
    end
  end
endmodule // osm_top

// >>> bench/osm_top_chk.sv
// Concurrent checks on the ports of the oscillator select block.
// Assumes one ref_clk domain with a synchronous active-low reset.
`timescale 1ns/1ps
module osm_top_chk (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Fuses and power state.
  input wire osm_pkg::osm_group_t group_select_config,
  input wire osm_pkg::osm_fpr_t primary_select_config,
  input wire osm_pkg::osm_cfg_t switch_monitor_config,
  input wire logic sleep,
  input wire logic power_up_timer_done_pin,
  // Clock tree control.
  input wire osm_pkg::osm_group_t sys_group,
  input wire logic pll_from_fast_rc,
  input wire osm_pkg::osm_gain_t pll_gain,
  input wire logic low_power_internal_rc_run,
  input wire logic clock_fail_trap
);
  import osm_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_trap_grp;
    clock_fail_trap |=> sys_group == 3'h1;
  endproperty
  a_trap_grp: assert property (p_trap_grp) else $error("trap without fast rc");
  property p_trap_pulse;
    clock_fail_trap |=> !clock_fail_trap;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap too long");
  property p_gain;
    $past(rst_n) |-> pll_gain == primary_select_config[1:0];
  endproperty
  a_gain: assert property (p_gain) else $error("pll gain wrong");
  property p_pll_frc;
    $past(rst_n) |-> pll_from_fast_rc == (primary_select_config inside {5'h05, 5'h06, 5'h07});
  endproperty
  a_pll_frc: assert property (p_pll_frc) else $error("pll source wrong");
  property p_grp_legal;
    sys_group inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  endproperty
  a_grp_legal: assert property (p_grp_legal) else $error("illegal group");
  property p_no_mon;
    switch_monitor_config != 2'h0 |-> !clock_fail_trap;
  endproperty
  a_no_mon: assert property (p_no_mon) else $error("trap with monitor off");
  property p_fixed;
    switch_monitor_config[1] && $past(rst_n) |-> sys_group == group_select_config;
  endproperty
  a_fixed: assert property (p_fixed) else $error("group not from fuses");
  property p_low_power_internal_rc_boot;
    !power_up_timer_done_pin [*4] |-> low_power_internal_rc_run;
  endproperty
  a_low_power_internal_rc_boot: assert property (p_low_power_internal_rc_boot) else $error("low_power_internal_rc off at boot");
  property p_low_power_internal_rc_mon;
    (switch_monitor_config == 2'h0 && power_up_timer_done_pin && !sleep) [*6] |-> low_power_internal_rc_run;
  endproperty
  a_low_power_internal_rc_mon: assert property (p_low_power_internal_rc_mon) else $error("low_power_internal_rc off with monitor");
  property p_low_power_internal_rc_sleep;
    (switch_monitor_config == 2'h0 && power_up_timer_done_pin && sleep) [*6] |-> !low_power_internal_rc_run;
  endproperty
  a_low_power_internal_rc_sleep: assert property (p_low_power_internal_rc_sleep) else $error("low_power_internal_rc on in sleep");
  c_trap: cover property (clock_fail_trap);
  c_ext: cover property (sys_group == 3'h3);
  c_sleep: cover property (sleep && !low_power_internal_rc_run);
endmodule // osm_top_chk

bind osm_top osm_top_chk u_osm_top_chk (
  .ref_clk, .rst_n, .group_select_config, .primary_select_config, .switch_monitor_config,
  .sleep, .power_up_timer_done_pin, .sys_group, .pll_from_fast_rc, .pll_gain, .low_power_internal_rc_run,
  .clock_fail_trap
);

// >>> bench/osm_osc_model.sv
// Behavioural oscillator sources and PLL seen by the block.
// Assumes the block's run enables are levels on ref_clk.
`timescale 1ns/1ps
module osm_osc_model (
  // Clock.
  input wire logic ref_clk,
  // Enables from the block.
  input wire logic pri_osc_run,
  input wire logic sec_osc_run,
  input wire logic pll_enable,
  // Fault injection.
  input wire logic stall,
  // Oscillator taps.
  output logic pri_osc_pin,
  output logic sec_osc_pin,
  output logic pll_lock_pin
);
  logic [2:0] div;
  initial begin
    div = 3'h0;
    pri_osc_pin = 1'b0;
    sec_osc_pin = 1'b0;
    pll_lock_pin = 1'b0;
  end
  // A stopped or stalled crystal holds its pin, which is what the monitor must catch.
  always @(posedge ref_clk) begin
    div <= div + 3'h1;
    if (pri_osc_run && !stall && div[0]) pri_osc_pin <= !pri_osc_pin;
    if (sec_osc_run && div == 3'h7) sec_osc_pin <= !sec_osc_pin;
    pll_lock_pin <= pll_enable;
  end
endmodule // osm_osc_model

// >>> bench/osm_top_test.sv
// Self-checking bench of the oscillator select block over AHB-Lite.
// Assumes the oscillator model on the pins and the bound checker.
`timescale 1ns/1ps
`include "osm_consts.svh"
module osm_top_test;
  import osm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  osm_group_t gsel = 3'h1;
  osm_cfg_t smc = 2'h0;
  osm_fpr_t fpr = 5'h04;
  logic rel, resp, pfr;
  osm_gain_t gain;
  logic sleep = 1'b0;
  logic pup = 1'b0;
  logic stall = 1'b0;
  logic pri_pin, sec_pin, lock_pin, pll_en, pri_run, sec_run, frc_run, low_power_internal_rc_run, trap;
  osm_group_t sys_group;
  osm_trim_t trim;
  int num_errors = 0;
  int compares = 0;
  logic [31:0] q;
  always #12.5 ref_clk = ~ref_clk;
  osm_top u_osm_top (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(resp), .group_select_config(gsel),
    .primary_select_config(fpr), .switch_monitor_config(smc), .sleep(sleep),
    .watchdog_enable(1'b0), .power_up_timer_done_pin(pup), .pri_osc_pin(pri_pin),
    .sec_osc_pin(sec_pin), .pll_lock_pin(lock_pin), .sys_group(sys_group),
    .sys_clk_release(rel), .pll_enable(pll_en), .pll_from_fast_rc(pfr), .pll_gain(gain),
    .fast_rc_trim(trim), .pri_osc_run(pri_run), .sec_osc_run(sec_run),
    .fast_rc_run(frc_run), .low_power_internal_rc_run(low_power_internal_rc_run), .clock_fail_trap(trap));
  osm_osc_model u_osm_osc_model (.ref_clk(ref_clk), .pri_osc_run(pri_run),
    .sec_osc_run(sec_run), .pll_enable(pll_en), .stall(stall), .pri_osc_pin(pri_pin),
    .sec_osc_pin(sec_pin), .pll_lock_pin(lock_pin));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input string n, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    tick(2);
    rst_n <= 1'b1;
    tick(8);
    pup <= 1'b1;
    tick(4);
    rd(`OSM_ADDR_CTRL, "ctrl reset", 32'h1100);
    chk("hresp", 32'h0, {31'h0, resp});
    bus(1'b0, `OSM_ADDR_STAT, 32'h0);
    chk("status", 32'h1040, q & 32'hffff_fffc);
    rd(12'h00c, "unmapped", 32'h0);
    rd(`OSM_ADDR_TRIM, "trim reset", 32'h0);
    bus(1'b1, `OSM_ADDR_TRIM, 32'hffff_fff8);
    rd(`OSM_ADDR_TRIM, "trim", 32'h8);
    chk("trim out", 32'h8, {28'h0, trim});
    $display("test reset and trim done");
    // The current group bits are written as 111 to show they are read-only.
    bus(1'b1, `OSM_ADDR_CTRL, 32'h7303);
    tick(3500);
    chk("group early", 32'h1, {29'h0, sys_group});
    chk("sec run", 32'h1, {31'h0, sec_run});
    repeat (3000) if (sys_group !== 3'h3) @(posedge ref_clk);
    chk("group ext", 32'h3, {29'h0, sys_group});
    chk("release ext", 32'h1, {31'h0, rel});
    rd(`OSM_ADDR_CTRL, "ctrl ext", 32'h3302);
    $display("test switch done");
    stall <= 1'b1;
    repeat (1000) if (trap !== 1'b1) @(posedge ref_clk);
    chk("trap", 32'h1, {31'h0, trap});
    tick(2);
    chk("group fail", 32'h1, {29'h0, sys_group});
    chk("frc run", 32'h1, {31'h0, frc_run});
    stall <= 1'b0;
    rd(`OSM_ADDR_CTRL, "ctrl fail", 32'h130a);
    bus(1'b1, `OSM_ADDR_CTRL, 32'h030a);
    rd(`OSM_ADDR_CTRL, "fail sticky", 32'h130a);
    bus(1'b1, `OSM_ADDR_CTRL, 32'h0302);
    rd(`OSM_ADDR_CTRL, "fail clear", 32'h1302);
    $display("test failure done");
    sleep <= 1'b1;
    tick(8);
    chk("low_power_internal_rc sleep", 32'h0, {31'h0, low_power_internal_rc_run});
    chk("sec sleep", 32'h1, {31'h0, sec_run});
    sleep <= 1'b0;
    tick(8);
    chk("low_power_internal_rc awake", 32'h1, {31'h0, low_power_internal_rc_run});
    $display("test sleep done");
    bus(1'b1, `OSM_ADDR_CTRL, 32'h0001);
    tick(4);
    rd(`OSM_ADDR_CTRL, "ctrl hang", 32'h1001);
    bus(1'b1, `OSM_ADDR_CTRL, 32'h0000);
    rd(`OSM_ADDR_CTRL, "ctrl abort", 32'h1000);
    chk("group abort", 32'h1, {29'h0, sys_group});
    $display("test abort done");
    rst_n <= 1'b0;
    smc <= 2'h2;
    gsel <= 3'h2;
    fpr <= 5'h06;
    tick(2);
    rst_n <= 1'b1;
    tick(4);
    bus(1'b1, `OSM_ADDR_CTRL, 32'h0101);
    tick(4);
    rd(`OSM_ADDR_CTRL, "ctrl fixed", 32'h2100);
    chk("group fixed", 32'h2, {29'h0, sys_group});
    chk("low_power_internal_rc group", 32'h1, {31'h0, low_power_internal_rc_run});
    chk("pll src", 32'h1, {31'h0, pfr});
    chk("pll gain", 32'h2, {30'h0, gain});
    $display("test fixed clock done");
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    report_and_stop();
  end
endmodule // osm_top_test
